// *** shared/irq_wake_map.vh ***
`ifndef IRQ_WAKE_MAP_VH
`define IRQ_WAKE_MAP_VH
// byte offsets of the register words
`define OFF_STATUS      8'h00
`define OFF_MASK        8'h04
`define OFF_CTRL        8'h08
`define OFF_FLAGS       8'h0C
`define OFF_VECTOR      8'h10
`define OFF_SAVED       8'h14
// pending flag positions
`define PF_TIMER        0
`define PF_CHANGE       1
`define PF_EXT          2
`define PF_CONV         3
`define PF_PWM1         4
`define PF_PWM2         5
`define PF_PWM3         6
`define PF_CMP          7
`define PF_LVD          8
// control register fields
`define CTL_EDGE        0
`define CTL_LOWFREQ     1
`define CTL_WATCHDOG    2
// flags register fields (timeout, power-down, global enable, sleep)
`define FLG_TO          0
`define FLG_PD          1
`define FLG_GIE         2
`define FLG_SLEEP       3
// reset values
`define MASK_RST        9'h000
`define CTRL_RST        3'h0
// noise filter length in system clocks
`define FILT_CYCLES     8
// vectors
`define VEC_EXT         10'h003
`define VEC_CHANGE      10'h006
`define VEC_TIMER       10'h009
`define VEC_CONV        10'h00C
`define VEC_CMP         10'h00F
`define VEC_PWM1        10'h012
`define VEC_PWM2        10'h015
`define VEC_PWM3        10'h018
`define VEC_LVD         10'h01B
`endif

// *** verilog/irq_wake_ctrl.v ***
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "irq_wake_map.vh"
module irq_wake_ctrl #(
  parameter NSRC = 9
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // reset causes and power events
  input  wire        power_on_pulse,
  input  wire        reset_pin_n,
  input  wire        low_voltage_reset,
  input  wire        watchdog_timeout,
  // core instruction strobes, vector entry strobe and context values
  input  wire        watchdog_clear_instruction,
  input  wire        sleep_instruction,
  input  wire        enable_interrupts_instruction,
  input  wire        disable_interrupts_instruction,
  input  wire        return_from_interrupt_instruction,
  input  wire        vector_taken,
  input  wire [7:0]  accumulator,
  input  wire [7:0]  status_core_register,
  input  wire [7:0]  file_select_register,
  // event sources
  input  wire        timer_counter_overflow,
  input  wire [7:0]  port6_pins,
  input  wire        port6_read,
  input  wire        ext_int_pin,
  input  wire        conversion_done,
  input  wire [2:0]  pwm_period_match,
  input  wire        comparator_out,
  input  wire        low_voltage_detect,
  // to the core
  output reg         core_reset,
  output reg         wake_up,
  output reg         irq_request,
  output reg  [9:0]  irq_vector,
  output reg  [7:0]  saved_accumulator,
  output reg  [7:0]  saved_status,
  output reg  [7:0]  saved_fsr,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  reg  [NSRC-1:0] pend_r;
  reg  [NSRC-1:0] mask_r;
  reg  [2:0]      ctrl_r;
  reg             to_r;
  reg             pd_r;
  reg             gie_r;
  reg             sleep_r;
  reg  [7:0]      port_ref_r;
  reg             ext_filt_r;
  reg             ext_prev_r;
  reg  [3:0]      filt_cnt_r;
  reg             cmp_prev_r;
  reg  [7:0]      aw_addr_r;
  reg  [31:0]     w_data_r;
  reg  [3:0]      w_strb_r;
  reg             aw_have_r;
  reg             w_have_r;
  reg  [NSRC-1:0] pend_nxt;
  reg  [NSRC-1:0] clr_mask;
  reg  [NSRC-1:0] win_sel;
  reg  [9:0]      win_vec;
  reg             win_any;

  wire        watchdog_reset = watchdog_timeout & ctrl_r[`CTL_WATCHDOG];
  wire        ext_raw   = ctrl_r[`CTL_LOWFREQ] ? ext_int_pin : ext_filt_r;
  wire        ext_edge  = ctrl_r[`CTL_EDGE] ? (ext_prev_r & ~ext_raw)
                                            : (~ext_prev_r & ext_raw);
  wire        change_ev = (port6_pins != port_ref_r);
  wire        wr_go     = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [NSRC-1:0] events = {low_voltage_detect, comparator_out ^ cmp_prev_r,
                            pwm_period_match, conversion_done, ext_edge,
                            change_ev & mask_r[`PF_CHANGE], timer_counter_overflow};

  // noise filter: level must stand 8 clocks before it is believed
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_filt_r <= 1'b0;
      filt_cnt_r <= 4'h0;
    end else if (ext_int_pin == ext_filt_r) begin
      filt_cnt_r <= 4'h0;
    end else if (filt_cnt_r == `FILT_CYCLES - 1) begin
      ext_filt_r <= ext_int_pin;
      filt_cnt_r <= 4'h0;
    end else begin
      filt_cnt_r <= filt_cnt_r + 4'h1;
    end
  end

  // priority pick: low-voltage first, then by vector order
  always @* begin
    win_sel = {NSRC{1'b0}};
    win_vec = 10'h000;
    win_any = 1'b0;
    if (pend_r[`PF_LVD] & mask_r[`PF_LVD]) begin
      win_sel[`PF_LVD] = 1'b1; win_vec = `VEC_LVD;
    end else if (pend_r[`PF_EXT] & mask_r[`PF_EXT]) begin
      win_sel[`PF_EXT] = 1'b1; win_vec = `VEC_EXT;
    end else if (pend_r[`PF_CHANGE] & mask_r[`PF_CHANGE]) begin
      win_sel[`PF_CHANGE] = 1'b1; win_vec = `VEC_CHANGE;
    end else if (pend_r[`PF_TIMER] & mask_r[`PF_TIMER]) begin
      win_sel[`PF_TIMER] = 1'b1; win_vec = `VEC_TIMER;
    end else if (pend_r[`PF_CONV] & mask_r[`PF_CONV]) begin
      win_sel[`PF_CONV] = 1'b1; win_vec = `VEC_CONV;
    end else if (pend_r[`PF_CMP] & mask_r[`PF_CMP]) begin
      win_sel[`PF_CMP] = 1'b1; win_vec = `VEC_CMP;
    end else if (pend_r[`PF_PWM1] & mask_r[`PF_PWM1]) begin
      win_sel[`PF_PWM1] = 1'b1; win_vec = `VEC_PWM1;
    end else if (pend_r[`PF_PWM2] & mask_r[`PF_PWM2]) begin
      win_sel[`PF_PWM2] = 1'b1; win_vec = `VEC_PWM2;
    end else if (pend_r[`PF_PWM3] & mask_r[`PF_PWM3]) begin
      win_sel[`PF_PWM3] = 1'b1; win_vec = `VEC_PWM3;
    end
    win_any = |win_sel;
  end

  // software clear of flags (write one to clear), set wins
  always @* begin
    clr_mask = {NSRC{1'b0}};
    if (wr_go && aw_addr_r == `OFF_STATUS) begin
      clr_mask = w_data_r[NSRC-1:0] & {{(NSRC-8){w_strb_r[1]}}, {8{w_strb_r[0]}}};
    end
    pend_nxt = (pend_r & ~clr_mask) | events;
  end

  // flags, mask, control, event history
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_r     <= {NSRC{1'b0}};
      mask_r     <= `MASK_RST;
      ctrl_r     <= `CTRL_RST;
      port_ref_r <= 8'h00;
      ext_prev_r <= 1'b0;
      cmp_prev_r <= 1'b0;
    end else begin
      pend_r     <= pend_nxt;
      ext_prev_r <= ext_raw;
      cmp_prev_r <= comparator_out;
      if (port6_read | change_ev)
        port_ref_r <= port6_pins;
      if (wr_go && aw_addr_r == `OFF_MASK && w_strb_r[0])
        mask_r[7:0] <= w_data_r[7:0];
      if (wr_go && aw_addr_r == `OFF_MASK && w_strb_r[1])
        mask_r[8] <= w_data_r[8];
      if (wr_go && aw_addr_r == `OFF_CTRL && w_strb_r[0])
        ctrl_r <= w_data_r[2:0];
    end
  end

  // timeout and power-down bits, sleep and global enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      to_r    <= 1'b1;
      pd_r    <= 1'b1;
      gie_r   <= 1'b0;
      sleep_r <= 1'b0;
    end else if (power_on_pulse) begin
      to_r <= 1'b1; pd_r <= 1'b1; gie_r <= 1'b0; sleep_r <= 1'b0;
    end else if (sleep_r) begin
      if (watchdog_reset) begin
        to_r <= 1'b0; pd_r <= 1'b0; sleep_r <= 1'b0;
      end else if (!reset_pin_n || low_voltage_reset ||
                   (change_ev && mask_r[`PF_CHANGE])) begin
        to_r <= 1'b1; pd_r <= 1'b0; sleep_r <= 1'b0;
      end
    end else if (watchdog_reset) begin
      to_r <= 1'b0; pd_r <= 1'b1; gie_r <= 1'b0;
    end else if (!reset_pin_n || low_voltage_reset) begin
      gie_r <= 1'b0;
    end else begin
      if (watchdog_clear_instruction) begin
        to_r <= 1'b1; pd_r <= 1'b1;
      end
      if (sleep_instruction) begin
        to_r <= 1'b1; pd_r <= 1'b0; sleep_r <= 1'b1;
      end
      if (vector_taken)
        gie_r <= 1'b0;
      else if (enable_interrupts_instruction | return_from_interrupt_instruction)
        gie_r <= 1'b1;
      else if (disable_interrupts_instruction)
        gie_r <= 1'b0;
    end
  end

  // core-facing outputs and context save
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_reset   <= 1'b1;
      wake_up      <= 1'b0;
      irq_request  <= 1'b0;
      irq_vector   <= 10'h000;
      saved_accumulator <= 8'h00;
      saved_status <= 8'h00;
      saved_fsr    <= 8'h00;
    end else begin
      core_reset  <= power_on_pulse | ~reset_pin_n | low_voltage_reset | watchdog_reset;
      wake_up     <= sleep_r & change_ev & mask_r[`PF_CHANGE];
      irq_request <= gie_r & win_any & ~vector_taken;
      irq_vector  <= win_vec;
      if (vector_taken) begin
        saved_accumulator <= accumulator;
        saved_status <= status_core_register;
        saved_fsr    <= file_select_register;
      end
    end
  end

  // axi4-lite write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0; w_have_r <= 1'b0;
      aw_addr_r <= 8'h00; w_data_r <= 32'h00000000; w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1; aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1; w_data_r <= s_axi_wdata; w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == `OFF_STATUS || aw_addr_r == `OFF_MASK ||
                         aw_addr_r == `OFF_CTRL) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0; aw_have_r <= 1'b0; w_have_r <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000; s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (s_axi_araddr == `OFF_STATUS)
          s_axi_rdata <= {23'h0, pend_r & mask_r};
        else if (s_axi_araddr == `OFF_MASK)
          s_axi_rdata <= {23'h0, mask_r};
        else if (s_axi_araddr == `OFF_CTRL)
          s_axi_rdata <= {29'h0, ctrl_r};
        else if (s_axi_araddr == `OFF_FLAGS)
          s_axi_rdata <= {28'h0, sleep_r, gie_r, pd_r, to_r};
        else if (s_axi_araddr == `OFF_VECTOR)
          s_axi_rdata <= {21'h0, win_any, win_vec};
        else if (s_axi_araddr == `OFF_SAVED)
          s_axi_rdata <= {8'h00, saved_fsr, saved_status, saved_accumulator};
        else begin
          s_axi_rdata <= 32'h00000000; s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // irq_wake_ctrl

// *** testbench/irq_wake_ctrl_props.sv ***
`timescale 1ns/1ps
`include "irq_wake_map.vh"
module irq_wake_props (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // watched inputs
  input wire        power_on_pulse,
  input wire        reset_pin_n,
  input wire        vector_taken,
  input wire        enable_interrupts_instruction,
  input wire        return_from_interrupt_instruction,
  input wire [7:0]  accumulator,
  // watched outputs and bus ready inputs
  input wire        core_reset,
  input wire        irq_request,
  input wire [9:0]  irq_vector,
  input wire [7:0]  saved_accumulator,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready
);
  // no enable or return strobe this cycle
  wire quiet = !enable_interrupts_instruction && !return_from_interrupt_instruction;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers hold until taken
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_ar_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("read taken while answer open");
  // vector table and context capture
  property p_vec; irq_request |-> irq_vector inside {`VEC_EXT, `VEC_CHANGE, `VEC_TIMER,
    `VEC_CONV, `VEC_CMP, `VEC_PWM1, `VEC_PWM2, `VEC_PWM3, `VEC_LVD}; endproperty
  a_vec: assert property (p_vec) else $error("vector off table");
  property p_save; vector_taken |=> saved_accumulator == $past(accumulator); endproperty
  a_save: assert property (p_save) else $error("context not saved");
  property p_gie; vector_taken && quiet ##1 quiet [*2] |-> !irq_request; endproperty
  a_gie: assert property (p_gie) else $error("enable kept on entry");
  // reset causes
  property p_pin; !reset_pin_n |=> core_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missed");
  property p_por; power_on_pulse |=> core_reset; endproperty
  a_por: assert property (p_por) else $error("power-on reset missed");
  c_vec: cover property (vector_taken);
  c_rst: cover property (core_reset);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // irq_wake_props
bind irq_wake_ctrl irq_wake_props irq_wake_props_inst (.aclk(aclk), .aresetn(aresetn),
  .power_on_pulse(power_on_pulse), .reset_pin_n(reset_pin_n), .vector_taken(vector_taken),
  .enable_interrupts_instruction(enable_interrupts_instruction),
  .return_from_interrupt_instruction(return_from_interrupt_instruction),
  .accumulator(accumulator), .core_reset(core_reset), .irq_request(irq_request),
  .irq_vector(irq_vector), .saved_accumulator(saved_accumulator), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// *** testbench/core_model.sv ***
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // request side
  input wire       irq_request,
  input wire [1:0] lag,
  // entry strobe
  output reg       vector_taken
);
  reg [1:0] cnt_r;
  reg       busy_r;
  // one entry per raised request, after a varying delay
  always @(posedge aclk) begin
    vector_taken <= 1'b0;
    if (!aresetn) begin
      cnt_r <= 2'h0;
      busy_r <= 1'b0;
    end else if (busy_r) begin
      busy_r <= irq_request;
    end else if (irq_request && cnt_r >= lag) begin
      vector_taken <= 1'b1;
      busy_r <= 1'b1;
      cnt_r <= 2'h0;
    end else if (irq_request) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule // core_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`include "irq_wake_map.vh"
module testbench;
  reg        aclk, aresetn, pin_n, por, lv_rst, ext, cmp, awv, wv, bre, arv, rre, vt_d;
  reg  [5:0] ins, junk;
  reg  [7:0] ev, p6, accum, st, fs, awa, ara;
  reg [23:0] ctx_e;
  reg  [1:0] lag;
  reg [31:0] wd;
  reg [63:0] q;
  wire       wake, irq, awr, wrd, bv, arr, rv, vt, crst;
  wire [7:0] sacc, sst, sfs;
  wire [9:0] vec;
  wire [1:0] br, rr;
  wire[31:0] rdat;
  int        err_count, n_tests, i, k;
  reg [63:0] rq[$];
  reg  [9:0] vq[$];
  int        pb[8] = '{8, 1, 0, 3, 7, 4, 5, 6};
  reg  [9:0] pv[8] = '{`VEC_LVD, `VEC_CHANGE, `VEC_TIMER, `VEC_CONV, `VEC_CMP, `VEC_PWM1,
                       `VEC_PWM2, `VEC_PWM3};
  irq_wake_ctrl irq_wake_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .power_on_pulse(por),
    .reset_pin_n(pin_n), .low_voltage_reset(lv_rst), .watchdog_timeout(ev[6]),
    .watchdog_clear_instruction(ins[0]), .sleep_instruction(ins[1]),
    .enable_interrupts_instruction(ins[2]), .disable_interrupts_instruction(ins[3]),
    .return_from_interrupt_instruction(ins[4]), .vector_taken(vt), .accumulator(accum),
    .status_core_register(st), .file_select_register(fs), .timer_counter_overflow(ev[0]),
    .port6_pins(p6), .port6_read(ins[5]), .ext_int_pin(ext), .conversion_done(ev[1]),
    .pwm_period_match(ev[4:2]), .comparator_out(cmp), .low_voltage_detect(ev[5]),
    .core_reset(crst), .wake_up(wake), .irq_request(irq), .irq_vector(vec),
    .saved_accumulator(sacc), .saved_status(sst), .saved_fsr(sfs), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  core_model core_model_inst (.aclk(aclk), .aresetn(aresetn), .irq_request(irq),
    .lag(lag), .vector_taken(vt));
  task check(input string n, input [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task hang(input int j);
    if (j >= 200) begin
      err_count++;
      complete_run;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one-cycle instruction and event strobes, bit 7 toggles the comparator
  task op(input [5:0] o, input [7:0] e);
    @(posedge aclk);
    ins <= o;
    ev <= e;
    cmp <= cmp ^ e[7];
    @(posedge aclk);
    ins <= 6'h00;
    ev <= 8'h00;
  endtask
  // bus write, response checked at once
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (i = 0; i < 200 && (awv || wv || !bv); i++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    hang(i);
    check("bresp", br, r);
    bre <= 1'b0;
  endtask
  // bus read, expectation noted for the watcher
  task rd(input [7:0] a, input [31:0] m, e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    rq.push_back({m, e});
    for (i = 0; i < 200 && (arv || !rv); i++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    hang(i);
    rre <= 1'b0;
  endtask
  task wait_vt;
    for (k = 0; k < 200 && !vt; k++) tick(1);
    hang(k);
  endtask
  // watcher: reads and vector entries against the oldest note, saved context against the values captured at entry
  always @(posedge aclk) begin
    if (rv && rre) begin
      q = rq.pop_front();
      check("read", rdat & q[63:32], q[31:0]);
      check("rresp", rr, 0);
    end
    if (vt) check("vector", vec, vq.size() ? vq.pop_front() : 10'h3FF);
    if (vt_d) check("saved context", {sfs, sst, sacc}, ctx_e);
    vt_d <= vt;
    if (vt) ctx_e <= {fs, st, accum};
  end
  // context and entry delay vary every cycle
  always @(posedge aclk) {junk, lag, accum, st, fs} <= $urandom;
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    k = $urandom(11);
    {aresetn, por, lv_rst, ext, cmp, ins, ev, p6, awa, ara, wd, awv, wv, bre, arv, rre} = 0;
    pin_n = 1'b1;
    tick(20);
    aresetn <= 1'b1;
    rd(`OFF_FLAGS, 32'hF, 32'h3);
    rd(`OFF_MASK, 32'h1FF, 0);
    wr(8'h40, 32'h1, 2'h2);
    op(6'h01, 0);
    rd(`OFF_FLAGS, 32'h3, 32'h3);
    wr(`OFF_CTRL, 32'h4, 0);
    op(0, 8'h40);
    rd(`OFF_FLAGS, 32'h3, 32'h2);
    pin_n <= 1'b0;
    tick(3);
    check("core_reset", crst, 1);
    pin_n <= 1'b1;
    rd(`OFF_FLAGS, 32'h3, 32'h2);
    check("core_reset", crst, 0);
    op(6'h02, 0);
    rd(`OFF_FLAGS, 32'h3, 32'h1);
    wr(`OFF_CTRL, 32'h4, 0);
    op(0, 8'h40);
    rd(`OFF_FLAGS, 32'h3, 32'h0);
    op(6'h02, 0);
    pin_n <= 1'b0;
    tick(3);
    pin_n <= 1'b1;
    rd(`OFF_FLAGS, 32'h3, 32'h1);
    por <= 1'b1;
    tick(2);
    check("core_reset", crst, 1);
    por <= 1'b0;
    rd(`OFF_FLAGS, 32'h3, 32'h3);
    wr(`OFF_MASK, 32'h2, 0);
    op(6'h20, 0);
    op(6'h02, 0);
    p6 <= ~p6;
    for (k = 0; k < 200 && !wake; k++) tick(1);
    hang(k);
    rd(`OFF_FLAGS, 32'h3, 32'h1);
    rd(`OFF_STATUS, 32'h1FF, 32'h2);
    check("irq", irq, 0);
    wr(`OFF_STATUS, 32'h2, 0);
    wr(`OFF_MASK, 0, 0);
    op(0, 8'h01);
    rd(`OFF_STATUS, 32'h1FF, 0);
    wr(`OFF_MASK, 32'h1, 0);
    rd(`OFF_STATUS, 32'h1FF, 32'h1);
    wr(`OFF_STATUS, 32'h1, 0);
    wr(`OFF_MASK, 32'h4, 0);
    wr(`OFF_CTRL, 0, 0);
    op(0, 8'h40);
    rd(`OFF_FLAGS, 32'h3, 32'h1);
    ext <= 1'b1;
    tick(6);
    ext <= 1'b0;
    rd(`OFF_STATUS, 32'h1FF, 0);
    ext <= 1'b1;
    tick(12);
    ext <= 1'b0;
    rd(`OFF_STATUS, 32'h1FF, 32'h4);
    wr(`OFF_STATUS, 32'h4, 0);
    wr(`OFF_CTRL, 32'h3, 0);
    ext <= 1'b1;
    tick(2);
    rd(`OFF_STATUS, 32'h1FF, 0);
    ext <= 1'b0;
    tick(2);
    rd(`OFF_STATUS, 32'h1FF, 32'h4);
    vq.push_back(`VEC_EXT);
    op(6'h04, 0);
    wait_vt;
    wr(`OFF_STATUS, 32'h4, 0);
    op(6'h10, 0);
    op(6'h20, 0);
    wr(`OFF_MASK, 32'h1FB, 0);
    op(6'h08, 0);
    p6 <= ~p6;
    op(0, 8'hBF);
    tick(6);
    rd(`OFF_VECTOR, 32'h7FF, 32'h41B);
    foreach (pv[j]) vq.push_back(pv[j]);
    op(6'h04, 0);
    for (int j = 0; j < 8; j++) begin
      wait_vt;
      wr(`OFF_STATUS, 32'h1 << pb[j], 0);
      op(6'h10, 0);
    end
    rd(`OFF_SAVED, 32'hFFFFFF, {8'h00, ctx_e});
    tick(10);
    check("pending vectors", vq.size(), 0);
    complete_run;
  end
endmodule // testbench
